/* pulse_result_pkg.sv */
// constants for the pulse result record writer
package pulse_result_pkg;

   // ***************************************************************
   // record word layout
   // ***************************************************************
   localparam int          MEM_W       = 18;         // tag plus payload
   localparam int          MEM_AW      = 5;          // record address width
   localparam int          PAY_W       = 16;         // payload width
   localparam logic [1:0]  TAG_DATA    = 2'h0;       // plain data word
   localparam logic [1:0]  TAG_NOEV    = 2'h1;       // no-event stamp word
   localparam logic [1:0]  TAG_PHDR    = 2'h2;       // pulse header word
   localparam logic [1:0]  TAG_END     = 2'h3;       // end of window
   localparam logic [4:0]  TRIG_CODE   = 5'h12;      // word 0 code
   localparam logic [7:0]  STAMP_CODE  = 8'h98;      // word 2 code
   localparam logic [17:0] FILL_WORD   = 18'h10000;  // no-event filler
   localparam logic [15:0] END_PAY     = 16'h0000;   // end marker payload

   // ***************************************************************
   // record locations and counts
   // ***************************************************************
   localparam logic [4:0]  LOC_TNUM_HI = 5'h00;
   localparam logic [4:0]  LOC_TNUM_LO = 5'h01;
   localparam logic [4:0]  LOC_TS_HI   = 5'h02;
   localparam logic [4:0]  LOC_TS_MID  = 5'h03;
   localparam logic [4:0]  LOC_TS_LO1  = 5'h04;
   localparam logic [4:0]  LOC_TS_LO2  = 5'h05;
   localparam logic [4:0]  LOC_FILL2   = 5'h07;
   localparam logic [4:0]  LOC_LAST    = 5'h12;      // highest location, 18
   localparam logic [2:0]  MAX_PULSES  = 3'h4;

   // ***************************************************************
   // pulse entry fifo
   // ***************************************************************
   localparam int          FIFO_DEPTH  = 16;
   localparam int          SAMP_W      = 10;
   localparam int          SUM_W       = 19;
   localparam int          FINE_W      = 6;
   localparam int          VAL_W       = 12;
   localparam int          ENTRY_W     = 1 + SAMP_W + SUM_W + FINE_W + 2 * VAL_W;

endpackage

/* pulse_result_memory_writer.sv */
// pulse entry fifo and per-trigger result record writer

// ***************************************************************
// pulse entry fifo
// ***************************************************************
module pulse_entry_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         srst,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem_r [D];
   logic [AW:0]  wp_r;
   logic [AW:0]  wp_nxt;
   logic [AW:0]  rp_r;
   logic [AW:0]  rp_nxt;
   logic         push;
   logic         pop;

   // full and empty from pointer wrap bit
   assign in_ready  = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
   assign out_valid = (wp_r != rp_r);
   assign out_data  = mem_r[rp_r[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // pointer next values
   always_comb begin
      wp_nxt = push ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop ? rp_r + 1'b1 : rp_r;
   end

   // storage and pointers
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wp_r[AW-1:0]] <= in_data;
      end
      if (srst) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end
endmodule

// ***************************************************************
// record writer
// ***************************************************************
module pulse_result_memory_writer (
   // clock and reset
   input  wire logic                                  clk,
   input  wire logic                                  srst,
   // record start
   input  wire logic                                  rec_valid,
   output logic                                       rec_ready,
   input  wire logic                                  mode_timing,
   input  wire logic [26:0]                           trig_num,
   input  wire logic [47:0]                           time_stamp,
   // pulse entries and window end
   input  wire logic                                  pulse_valid,
   output logic                                       pulse_ready,
   input  wire logic                                  pulse_win_end,
   input  wire logic [pulse_result_pkg::SAMP_W-1:0]   samples_from_crossing,
   input  wire logic [pulse_result_pkg::SUM_W-1:0]    pulse_sum,
   input  wire logic [pulse_result_pkg::FINE_W-1:0]   fine_time,
   input  wire logic [pulse_result_pkg::VAL_W-1:0]    pulse_floor,
   input  wire logic [pulse_result_pkg::VAL_W-1:0]    pulse_peak,
   // processing memory write port
   output logic                                       mem_we,
   output logic [pulse_result_pkg::MEM_AW-1:0]        mem_addr,
   output logic [pulse_result_pkg::MEM_W-1:0]         mem_wdata,
   output logic                                       rec_done
);
   import pulse_result_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE, S_HEAD, S_WAIT, S_STAMP, S_PHDR, S_PW1, S_PW2, S_NOEV, S_END
   } wr_state_e;

   wr_state_e           st_r, st_nxt;
   logic [MEM_AW-1:0]   cur_r, cur_nxt;
   logic [2:0]          cnt_r, cnt_nxt;
   logic                ev_r, ev_nxt;
   logic                tmode_r, tmode_nxt;
   logic [26:0]         tnum_r, tnum_nxt;
   logic [47:0]         ts_r, ts_nxt;
   logic                we_nxt;
   logic [MEM_AW-1:0]   addr_nxt;
   logic [MEM_W-1:0]    wdata_nxt;
   logic                done_nxt;
   logic [ENTRY_W-1:0]  q_data;
   logic                q_valid;
   logic                q_pop;
   logic                q_end;
   logic [SAMP_W-1:0]   q_samp;
   logic [SUM_W-1:0]    q_sum;
   logic [FINE_W-1:0]   q_fine;
   logic [VAL_W-1:0]    q_floor;
   logic [VAL_W-1:0]    q_peak;

   // pulse entries queue up while the header is written
   pulse_entry_fifo #(.W(ENTRY_W), .D(FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .srst      (srst),
      .in_valid  (pulse_valid),
      .in_ready  (pulse_ready),
      .in_data   ({pulse_win_end, samples_from_crossing, pulse_sum, fine_time,
                   pulse_floor, pulse_peak}),
      .out_valid (q_valid),
      .out_ready (q_pop),
      .out_data  (q_data)
   );

   // unpack queue head
   assign {q_end, q_samp, q_sum, q_fine, q_floor, q_peak} = q_data;
   assign rec_ready = (st_r == S_IDLE);

   // header word for locations 0 to 3
   function automatic logic [MEM_W-1:0] head_word(input logic [1:0] idx,
                                                  input logic [26:0] tn,
                                                  input logic [47:0] ts);
      logic [MEM_W-1:0] w;
      w = {TAG_DATA, tn[15:0]};
      case (idx)
         LOC_TNUM_HI[1:0]: w = {TAG_DATA, TRIG_CODE, tn[26:16]};
         LOC_TNUM_LO[1:0]: w = {TAG_DATA, tn[15:0]};
         LOC_TS_HI[1:0]:   w = {TAG_DATA, STAMP_CODE, ts[47:40]};
         LOC_TS_MID[1:0]:  w = {TAG_DATA, ts[39:24]};
         default:          w = {TAG_DATA, tn[15:0]};
      endcase
      return w;
   endfunction

   // record sequencing and word formation
   always_comb begin
      st_nxt    = st_r;
      cur_nxt   = cur_r;
      cnt_nxt   = cnt_r;
      ev_nxt    = ev_r;
      tmode_nxt = tmode_r;
      tnum_nxt  = tnum_r;
      ts_nxt    = ts_r;
      we_nxt    = 1'b0;
      addr_nxt  = cur_r;
      wdata_nxt = mem_wdata;
      done_nxt  = 1'b0;
      q_pop     = 1'b0;
      case (st_r)
         S_IDLE: begin
            if (rec_valid) begin
               tnum_nxt  = trig_num;
               ts_nxt    = time_stamp;
               tmode_nxt = mode_timing;
               cur_nxt   = LOC_TNUM_HI;
               cnt_nxt   = 3'h0;
               st_nxt    = S_HEAD;
            end
         end
         S_HEAD: begin
            we_nxt    = 1'b1;
            wdata_nxt = head_word(cur_r[1:0], tnum_r, ts_r);
            cur_nxt   = cur_r + 5'h01;
            if (cur_r == LOC_TS_MID) begin
               st_nxt = S_WAIT;
            end
         end
         S_WAIT: begin
            if (q_valid) begin
               if (cur_r == LOC_TS_LO1) begin
                  ev_nxt = !q_end;                          // first entry decides layout
                  st_nxt = S_STAMP;
               end else if (q_end) begin
                  q_pop  = 1'b1;
                  st_nxt = ev_r ? S_END : S_NOEV;
               end else if (cnt_r == MAX_PULSES) begin
                  q_pop  = 1'b1;                            // fifth pulse on is dropped
               end else begin
                  st_nxt = S_PHDR;
               end
            end
         end
         S_STAMP: begin
            we_nxt  = 1'b1;
            cur_nxt = cur_r + 5'h01;
            if (cur_r == LOC_TS_LO1) begin
               wdata_nxt = {ev_r ? TAG_DATA : TAG_NOEV, 8'h00, ts_r[23:16]};
            end else begin
               wdata_nxt = {ev_r ? TAG_DATA : TAG_NOEV, ts_r[15:0]};
               st_nxt    = S_WAIT;
            end
         end
         S_PHDR: begin
            we_nxt    = 1'b1;
            cur_nxt   = cur_r + 5'h01;
            wdata_nxt = {TAG_PHDR, 4'h0, cnt_r[1:0], q_samp};
            st_nxt    = S_PW1;
         end
         S_PW1: begin
            we_nxt  = 1'b1;
            cur_nxt = cur_r + 5'h01;
            if (tmode_r) begin
               wdata_nxt = {TAG_DATA, q_fine, 2'h0, q_floor[11:4]};
            end else begin
               wdata_nxt = {TAG_DATA, q_sum[18:3]};
            end
            st_nxt = S_PW2;
         end
         S_PW2: begin
            we_nxt  = 1'b1;
            cur_nxt = cur_r + 5'h01;
            if (tmode_r) begin
               wdata_nxt = {TAG_DATA, q_floor[3:0], q_peak};
            end else begin
               wdata_nxt = {TAG_DATA, 13'h0000, q_sum[2:0]};
            end
            q_pop   = 1'b1;
            cnt_nxt = cnt_r + 3'h1;
            st_nxt  = S_WAIT;
         end
         S_NOEV: begin
            we_nxt    = 1'b1;
            cur_nxt   = cur_r + 5'h01;
            wdata_nxt = FILL_WORD;
            if (cur_r == LOC_FILL2) begin
               st_nxt = S_END;
            end
         end
         S_END: begin
            we_nxt    = 1'b1;
            wdata_nxt = {TAG_END, END_PAY};
            done_nxt  = 1'b1;
            st_nxt    = S_IDLE;
         end
         default: begin
            st_nxt = S_IDLE;
         end
      endcase
   end

   // state and output registers
   always_ff @(posedge clk) begin
      if (srst) begin
         st_r      <= S_IDLE;
         cur_r     <= '0;
         cnt_r     <= '0;
         ev_r      <= 1'b0;
         tmode_r   <= 1'b0;
         tnum_r    <= '0;
         ts_r      <= '0;
         mem_we    <= 1'b0;
         mem_addr  <= '0;
         mem_wdata <= '0;
         rec_done  <= 1'b0;
      end else begin
         st_r      <= st_nxt;
         cur_r     <= cur_nxt;
         cnt_r     <= cnt_nxt;
         ev_r      <= ev_nxt;
         tmode_r   <= tmode_nxt;
         tnum_r    <= tnum_nxt;
         ts_r      <= ts_nxt;
         mem_we    <= we_nxt;
         mem_addr  <= addr_nxt;
         mem_wdata <= wdata_nxt;
         rec_done  <= done_nxt;
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   tnum_hi_a: assert property (st_r == S_HEAD && cur_r == LOC_TNUM_HI |=> mem_we &&
      mem_addr == LOC_TNUM_HI && mem_wdata == {TAG_DATA, TRIG_CODE, tnum_r[26:16]})
      else $error("word 0 wrong");
   tnum_lo_a: assert property (st_r == S_HEAD && cur_r == LOC_TNUM_LO |=>
      mem_wdata == {TAG_DATA, tnum_r[15:0]}) else $error("word 1 wrong");
   stamp_hi_a: assert property (st_r == S_HEAD && cur_r == LOC_TS_HI |=>
      mem_wdata == {TAG_DATA, STAMP_CODE, ts_r[47:40]}) else $error("word 2 wrong");
   stamp_mid_a: assert property (st_r == S_HEAD && cur_r == LOC_TS_MID |=>
      mem_addr == LOC_TS_MID && mem_wdata == {TAG_DATA, ts_r[39:24]}) else $error("word 3 wrong");
   stamp_low_a: assert property (st_r == S_STAMP && cur_r == LOC_TS_LO2 && ev_r |=>
      mem_wdata == {TAG_DATA, ts_r[15:0]}) else $error("word 5 wrong");
   noev_fill_a: assert property (st_r == S_WAIT && cur_r != LOC_TS_LO1 && q_valid && q_end && !ev_r
      |=> ##1 mem_addr == 5'h06 && mem_wdata == FILL_WORD ##1 mem_wdata == FILL_WORD
      ##1 mem_addr == 5'h08 && mem_wdata[17:16] == TAG_END) else $error("no-event layout wrong");
   pulse_hdr_a: assert property (st_r == S_PHDR |=>
      mem_wdata == {TAG_PHDR, 4'h0, $past(cnt_r[1:0]), $past(q_samp)}) else $error("header wrong");
   pulse_cap_a: assert property (mem_we |-> mem_addr <= LOC_LAST && cnt_r <= MAX_PULSES)
      else $error("too many pulses");
   sum_hi_a: assert property (st_r == S_PW1 && !tmode_r |=>
      mem_wdata == {TAG_DATA, $past(q_sum[18:3])}) else $error("sum high wrong");
   sum_lo_a: assert property (st_r == S_PW2 && !tmode_r |=>
      mem_wdata == {TAG_DATA, 13'h0000, $past(q_sum[2:0])}) else $error("sum low wrong");
   end_mark_a: assert property (rec_done |-> mem_we && mem_wdata == {TAG_END, END_PAY})
      else $error("end marker wrong");
   fine_word_a: assert property (st_r == S_PW1 && tmode_r |=>
      mem_wdata == {TAG_DATA, $past(q_fine), 2'h0, $past(q_floor[11:4])}) else $error("fine wrong");
   peak_word_a: assert property (st_r == S_PW2 && tmode_r |=>
      mem_wdata == {TAG_DATA, $past(q_floor[3:0]), $past(q_peak)}) else $error("peak wrong");

   no_event_c: cover property (st_r == S_NOEV ##1 st_r == S_NOEV ##2 rec_done);
   four_pulse_c: cover property (rec_done && mem_addr == LOC_LAST);
   drop_pulse_c: cover property (st_r == S_WAIT && q_valid && !q_end && cnt_r == MAX_PULSES);
   timing_c: cover property (st_r == S_PW2 && tmode_r);
endmodule

/* record_reader.sv */
// downstream reader model of the processing memory
module record_reader (
   // clock and reset
   input  wire logic                                clk,
   input  wire logic                                srst,
   // processing memory write port
   input  wire logic                                mem_we,
   input  wire logic [pulse_result_pkg::MEM_AW-1:0] mem_addr,
   input  wire logic [pulse_result_pkg::MEM_W-1:0]  mem_wdata,
   input  wire logic                                rec_done,
   // reader results
   output logic [5:0]                               rec_len,
   output logic                                     skip_chan,
   output logic                                     order_err
);
   import pulse_result_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic [MEM_W-1:0]  mem [32];
   logic [MEM_AW-1:0] last_r;
   logic              scan_r;
   int                n;

   // store words, then scan one cycle after the record closes
   always @(posedge clk) begin
      if (srst) begin
         order_err <= 1'b0;
         last_r    <= 5'h00;
         scan_r    <= 1'b0;
         rec_len   <= 6'h00;
         skip_chan <= 1'b0;
      end else begin
         if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
            last_r        <= mem_addr;
            // addresses climb by one from location 0
            if (mem_addr != 5'h00 && mem_addr != last_r + 5'h01) order_err <= 1'b1;
         end
         scan_r <= rec_done;
         if (scan_r) begin
            n = 0;
            while (n < 31 && mem[n][17:16] !== TAG_END) n++;
            rec_len   <= 6'(n + 1);
            skip_chan <= (mem[6] === FILL_WORD);
         end
      end
   end
endmodule

/* test_pulse_result_memory_writer.sv */
// self-checking bench for the pulse result record writer
module test_pulse_result_memory_writer
   import pulse_result_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic              clk = 1'b0, srst = 1'b1, rec_valid = 1'b0, mode_timing = 1'b0;
   logic              pulse_valid = 1'b0, pulse_win_end = 1'b0;
   logic [26:0]       trig_num = '0;
   logic [47:0]       time_stamp = '0;
   logic [SAMP_W-1:0] samples_from_crossing = '0;
   logic [SUM_W-1:0]  pulse_sum = '0;
   logic [FINE_W-1:0] fine_time = '0;
   logic [VAL_W-1:0]  pulse_floor = '0, pulse_peak = '0;
   logic              rec_ready, pulse_ready, mem_we, rec_done, skip_chan, order_err;
   logic [MEM_AW-1:0] mem_addr;
   logic [MEM_W-1:0]  mem_wdata;
   logic [5:0]        rec_len;
   logic [SAMP_W-1:0] samp [16];
   logic [SUM_W-1:0]  sum [16];
   logic [FINE_W-1:0] fine [16];
   logic [VAL_W-1:0]  flr [16], pk [16];
   int                bad_count = 0, checks_done = 0, cycles = 0;

   pulse_result_memory_writer dut (.clk(clk), .srst(srst), .rec_valid(rec_valid),
      .rec_ready(rec_ready), .mode_timing(mode_timing), .trig_num(trig_num),
      .time_stamp(time_stamp), .pulse_valid(pulse_valid), .pulse_ready(pulse_ready),
      .pulse_win_end(pulse_win_end), .samples_from_crossing(samples_from_crossing),
      .pulse_sum(pulse_sum), .fine_time(fine_time), .pulse_floor(pulse_floor),
      .pulse_peak(pulse_peak), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .rec_done(rec_done));

   record_reader reader (.clk(clk), .srst(srst), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .rec_done(rec_done), .rec_len(rec_len),
      .skip_chan(skip_chan), .order_err(order_err));

   // ****
   // clock, timeout and helpers
   // ****
   always #4 clk = ~clk;

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         $display("[FAIL] run length expected below 5000 cycles seen 5000");
         end_sim;
      end
   end

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [17:0] seen, input logic [17:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // offer one entry, held until the fifo takes it
   task automatic push(input int i, input logic last);
      pulse_valid <= 1'b1;
      pulse_win_end <= last;
      samples_from_crossing <= samp[i];
      pulse_sum <= sum[i];
      fine_time <= fine[i];
      pulse_floor <= flr[i];
      pulse_peak <= pk[i];
      @(negedge clk);
      while (pulse_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
   endtask

   // n pulses from entry base, then the window end
   task automatic push_set(input int base, input int n);
      for (int k = 0; k < n; k++) push(base + k, 1'b0);
      push(0, 1'b1);
      pulse_valid <= 1'b0;
      pulse_win_end <= 1'b0;
   endtask

   task automatic start_rec(input logic md, input logic [26:0] tn, input logic [47:0] ts);
      rec_valid <= 1'b1;
      mode_timing <= md;
      trig_num <= tn;
      time_stamp <= ts;
      @(negedge clk);
      while (rec_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
      rec_valid <= 1'b0;
   endtask

   // wait for the record end, then compare every word
   task automatic check_rec(input logic md, input logic [26:0] tn, input logic [47:0] ts,
                            input int base, input int np);
      int          w;
      int          e;
      int          p;
      logic [1:0]  t;
      w = 0;
      do begin
         @(negedge clk);
         w++;
      end while (rec_done !== 1'b1 && w < 300);
      chk({17'h00000, rec_done}, 18'h00001, "rec_done");
      chk({17'h00000, rec_ready}, 18'h00001, "ready back");
      repeat (3) @(posedge clk);
      t = (np > 0) ? TAG_DATA : TAG_NOEV;
      e = (np > 0) ? 6 + 3 * np : 8;
      chk(reader.mem[0], {TAG_DATA, TRIG_CODE, tn[26:16]}, "word0");
      chk(reader.mem[1], {TAG_DATA, tn[15:0]}, "word1");
      chk(reader.mem[2], {TAG_DATA, STAMP_CODE, ts[47:40]}, "word2");
      chk(reader.mem[3], {TAG_DATA, ts[39:24]}, "word3");
      chk(reader.mem[4], {t, 8'h00, ts[23:16]}, "word4");
      chk(reader.mem[5], {t, ts[15:0]}, "word5");
      for (int k = 0; k < np; k++) begin
         p = base + k;
         chk(reader.mem[6+3*k], {TAG_PHDR, 4'h0, 2'(k), samp[p]}, "header");
         if (md) begin
            chk(reader.mem[7+3*k], {TAG_DATA, fine[p], 2'h0, flr[p][11:4]}, "t2");
            chk(reader.mem[8+3*k], {TAG_DATA, flr[p][3:0], pk[p]}, "t3");
         end else begin
            chk(reader.mem[7+3*k], {TAG_DATA, sum[p][18:3]}, "s2");
            chk(reader.mem[8+3*k], {TAG_DATA, 13'h0000, sum[p][2:0]}, "s3");
         end
      end
      if (np == 0) begin
         chk(reader.mem[6], FILL_WORD, "fill6");
         chk(reader.mem[7], FILL_WORD, "fill7");
      end
      chk(reader.mem[e], {TAG_END, END_PAY}, "end word");
      chk({12'h000, rec_len}, 18'(e + 1), "length");
      chk({17'h00000, skip_chan}, 18'(np == 0), "skip");
      chk({17'h00000, order_err}, 18'h00000, "order");
   endtask

   // ****
   // scenarios
   // ****
   task automatic t_sum_full;
      push_set(0, 4);
      start_rec(1'b0, 27'h5ABCDEF, 48'hA1B2C3D4E5F6);
      check_rec(1'b0, 27'h5ABCDEF, 48'hA1B2C3D4E5F6, 0, 4);
   endtask

   // entries arrive after the record has started
   task automatic t_time_late;
      start_rec(1'b1, 27'h0012345, 48'h0F1E2D3C4B5A);
      push_set(4, 2);
      check_rec(1'b1, 27'h0012345, 48'h0F1E2D3C4B5A, 4, 2);
   endtask

   task automatic t_noev;
      push_set(0, 0);
      start_rec(1'b0, 27'h7FFFFFF, 48'hFFFF00FF8001);
      check_rec(1'b0, 27'h7FFFFFF, 48'hFFFF00FF8001, 0, 0);
   endtask

   // fifo filled to refusal, extra pulses dropped
   task automatic t_fill;
      push_set(0, 15);
      @(negedge clk);
      chk({17'h00000, pulse_ready}, 18'h00000, "full");
      @(posedge clk);
      start_rec(1'b0, 27'h2468ACE, 48'h13579BDF0246);
      check_rec(1'b0, 27'h2468ACE, 48'h13579BDF0246, 0, 4);
      chk({17'h00000, pulse_ready}, 18'h00001, "drained");
   endtask

   // main sequence
   initial begin
      for (int i = 0; i < 16; i++) begin
         samp[i] = 10'h2A5 + 10'(i * 37);
         sum[i]  = 19'h6B3D7 - 19'(i * 4099);
         fine[i] = 6'h2D ^ 6'(i);
         flr[i]  = 12'hC5A + 12'(i * 5);
         pk[i]   = 12'h9E3 - 12'(i * 3);
      end
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      t_sum_full;
      t_time_late;
      t_noev;
      t_fill;
      end_sim;
   end
endmodule
